// file: design/ifs_map.vh
/*
 Register offsets, field positions, reset values and command codes for the
 interrupt flag, FIFO status and transmit length register bank.
 Assumes the includer provides the serial register port that uses them.
*/
// Contract
// RQ1 - Main flags zero at power-up and on default-restore.
// RQ2 - Reading main flags clears every bit except bit 0.
// RQ3 - Main bit 0 clears only after the auxiliary flags are read.
// RQ4 - Auxiliary flags at 0Bh: deselect, framing, parity, CRC, FIFO, EEPROM events.
// RQ5 - Parity or CRC errors keep data in FIFO and raise the flag.
// RQ6 - EEPROM done and error flags only for host-port write commands.
// RQ7 - EEPROM error on write-protected word or nonexistent address.
// RQ8 - Auxiliary bit 0 when tag activity cuts a host EEPROM access.
// RQ9 - Auxiliary flags clear on read, power-up and default-restore.
// RQ10 - FIFO status 1 bits 5:0 hold unread count 0 to 32.
// RQ11 - FIFO status zeroed at power-up, default-restore and FIFO-clear.
// RQ12 - Status 2 bit 6 underflow, bit 5 overflow; auxiliary bit 3 reports both.
// RQ13 - Incomplete last byte sets bit 4; bits 3:1 give valid MSB count.
// RQ14 - Missing parity on last byte sets bit 0 and counts as framing error.
// RQ15 - Host writes 10-bit full byte count split over 10h and 11h.
// RQ16 - Host never programs a full byte count above 1023.
// RQ17 - Offset 11h bits 2:0 give split byte bits; 000 means all full.
// RQ18 - Split bits apply only in level-3 mode with bit-stream transmit set.
// RQ19 - Full byte count fields reset to zero at power-up and default-restore.
// RQ20 - Main flags: power-up, wake-ups, rx start, rx end, tx end, water, aux.
// RQ21 - Water level flags nearly full on receive, nearly empty on transmit.
`ifndef IFS_MAP_VH
`define IFS_MAP_VH
`define IFS_OFF_MAIN_IRQ   6'h0a
`define IFS_OFF_AUX_IRQ    6'h0b
`define IFS_OFF_FIFO_STAT1 6'h0c
`define IFS_OFF_FIFO_STAT2 6'h0d
`define IFS_OFF_TX_HIGH    6'h10
`define IFS_OFF_TX_LOW     6'h11
`define IFS_AUX_DESELECT   7
`define IFS_AUX_FRAMING    6
`define IFS_AUX_PARITY     5
`define IFS_AUX_CRC        4
`define IFS_AUX_FIFO       3
`define IFS_AUX_EE_DONE    2
`define IFS_AUX_EE_ERR     1
`define IFS_AUX_EE_CUT     0
`define IFS_ST2_UNDERFLOW  6
`define IFS_ST2_OVERFLOW   5
`define IFS_ST2_INCOMPLETE 4
`define IFS_ST2_NOPARITY   0
`define IFS_RESET_BYTE     8'h00
`define IFS_FIFO_DEPTH     6'h20
`define IFS_WATER_RX       6'h18
`define IFS_WATER_TX       6'h08
`define IFS_SPI_CMD_BIT    7
`define IFS_CMD_SET_DEFAULT 6'h01
`define IFS_CMD_CLEAR      6'h02
`endif

// file: design/ifs_regs.v
/*
 Interrupt flag, FIFO status and transmit length register bank.
 Host access is a SPI-style serial port (mode 0, MSB first, 16-bit frames:
 bit 7 command, bit 6 read, bits 5:0 address, then one data byte). Event
 inputs are one-cycle pulses from logic on SYS_CLK_I.
*/
`timescale 1ns/10ps
`include "ifs_map.vh"
module ifs_regs #(
    parameter FIFO_CNT_W = 6
) (
    input  wire       SYS_CLK_I,
    input  wire       RESET_I,
    input  wire       SPI_SCLK_I,
    input  wire       SPI_CS_N_I,
    input  wire       SPI_MOSI_I,
    output reg        SPI_MISO_O,
    output wire       SPI_MISO_OE_O,
    input  wire       EV_POWER_UP_I,
    input  wire       EV_WAKE_ACTIVE_I,
    input  wire       EV_WAKE_CMD_I,
    input  wire       EV_RX_START_I,
    input  wire       EV_RX_END_I,
    input  wire       EV_TX_END_I,
    input  wire       EV_DESELECT_I,
    input  wire       EV_FRAMING_ERR_I,
    input  wire       EV_PARITY_ERR_I,
    input  wire       EV_CRC_ERR_I,
    input  wire       EV_EE_DONE_I,
    input  wire       EV_EE_ERR_I,
    input  wire       EV_EE_CUT_I,
    input  wire       EE_FROM_HOST_I,
    input  wire       RX_ACTIVE_I,
    input  wire       FIFO_PUSH_I,
    input  wire [7:0] FIFO_PUSH_DATA_I,
    input  wire       LAST_INCOMPLETE_I,
    input  wire [2:0] LAST_BYTE_BITS_I,
    input  wire       MISSING_PARITY_LAST_I,
    input  wire       LEVEL3_MODE_I,
    input  wire       BITSTREAM_TX_I,
    input  wire       FIFO_POP_I,
    output reg  [7:0] FIFO_POP_DATA_O,
    output wire [9:0] TX_FULL_BYTES_O,
    output wire [2:0] TX_SPLIT_BITS_O,
    output reg  [7:0] MAIN_IRQ_O
);
    reg [2:0] sclk_sync_reg, cs_sync_reg, mosi_sync_reg;
    reg [7:0] aux_irq_reg;
    reg [FIFO_CNT_W-1:0] fifo_count_reg;
    reg [4:0] rd_ptr_reg, wr_ptr_reg;
    reg [7:0] fifo_mem_reg [0:31];
    reg [7:0] fifo_status2_reg;
    reg [4:0] tx_high_reg;
    reg [7:0] tx_low_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] cmd_reg;
    reg [7:0] rd_data_reg;
    wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    wire cs_act    = ~cs_sync_reg[1];
    wire [7:0] in_byte = {shift_reg[6:0], mosi_sync_reg[1]};
    wire byte_done = cs_act & sclk_rise & (bit_cnt_reg[2:0] == 3'h7);
    wire first_done = byte_done & ~bit_cnt_reg[3];
    wire second_done = byte_done & bit_cnt_reg[3];
    wire is_cmd  = first_done & in_byte[`IFS_SPI_CMD_BIT];
    wire set_def = is_cmd & (in_byte[5:0] == `IFS_CMD_SET_DEFAULT);
    wire clr_cmd = is_cmd & (in_byte[5:0] == `IFS_CMD_CLEAR);
    wire rd_addr = first_done & ~in_byte[7] & in_byte[6];
    wire wr_done = second_done & ~cmd_reg[7] & ~cmd_reg[6];
    wire rd_main = rd_addr & (in_byte[5:0] == `IFS_OFF_MAIN_IRQ);
    wire rd_aux  = rd_addr & (in_byte[5:0] == `IFS_OFF_AUX_IRQ);
    wire fifo_full  = (fifo_count_reg == `IFS_FIFO_DEPTH);
    wire fifo_empty = (fifo_count_reg == 6'h00);
    wire do_push = FIFO_PUSH_I & ~fifo_full;
    wire do_pop  = FIFO_POP_I & ~fifo_empty;
    wire unf_ev  = FIFO_POP_I & fifo_empty;
    wire ovr_ev  = FIFO_PUSH_I & fifo_full & ~FIFO_POP_I;
    // RQ21 water level
    wire water_ev = RX_ACTIVE_I ? (do_push & (fifo_count_reg == `IFS_WATER_RX - 6'h01))
                                : (do_pop & (fifo_count_reg == `IFS_WATER_TX + 6'h01));
    reg [7:0] aux_set;
    // RQ4 auxiliary bit map
    always @* begin
        aux_set = 8'h00;
        aux_set[`IFS_AUX_DESELECT] = EV_DESELECT_I;
        // RQ14 framing from parity
        aux_set[`IFS_AUX_FRAMING]  = EV_FRAMING_ERR_I | (EV_RX_END_I & MISSING_PARITY_LAST_I);
        // RQ5 error flags
        aux_set[`IFS_AUX_PARITY]   = EV_PARITY_ERR_I;
        aux_set[`IFS_AUX_CRC]      = EV_CRC_ERR_I;
        // RQ12 fifo error summary
        aux_set[`IFS_AUX_FIFO]     = unf_ev | ovr_ev;
        // RQ6 host writes only
        aux_set[`IFS_AUX_EE_DONE]  = EV_EE_DONE_I & EE_FROM_HOST_I;
        // RQ7 protected address
        aux_set[`IFS_AUX_EE_ERR]   = EV_EE_ERR_I & EE_FROM_HOST_I;
        // RQ8 access cut
        aux_set[`IFS_AUX_EE_CUT]   = EV_EE_CUT_I & EE_FROM_HOST_I;
    end
    // RQ20 main flag events
    wire [7:1] main_set = {EV_POWER_UP_I, EV_WAKE_ACTIVE_I, EV_WAKE_CMD_I,
                           EV_RX_START_I, EV_RX_END_I, EV_TX_END_I, water_ev};
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg   <= 3'h7;
            mosi_sync_reg <= 3'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], SPI_SCLK_I};
            cs_sync_reg   <= {cs_sync_reg[1:0], SPI_CS_N_I};
            mosi_sync_reg <= {mosi_sync_reg[1:0], SPI_MOSI_I};
        end
    end
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            cmd_reg     <= 8'h00;
            rd_data_reg <= 8'h00;
            SPI_MISO_O  <= 1'b0;
        end else if (!cs_act) begin
            bit_cnt_reg <= 4'h0;
            SPI_MISO_O  <= 1'b0;
        end else begin
            if (sclk_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg   <= in_byte;
                if (first_done) begin
                    cmd_reg <= in_byte;
                    case (in_byte[5:0])
                        `IFS_OFF_MAIN_IRQ:   rd_data_reg <= MAIN_IRQ_O;
                        `IFS_OFF_AUX_IRQ:    rd_data_reg <= aux_irq_reg;
                        `IFS_OFF_FIFO_STAT1: rd_data_reg <= {2'b00, fifo_count_reg};
                        `IFS_OFF_FIFO_STAT2: rd_data_reg <= fifo_status2_reg;
                        `IFS_OFF_TX_HIGH:    rd_data_reg <= {3'b000, tx_high_reg};
                        `IFS_OFF_TX_LOW:     rd_data_reg <= tx_low_reg;
                        default:             rd_data_reg <= 8'h00;
                    endcase
                end
            end
            if (sclk_fall & bit_cnt_reg[3])
                SPI_MISO_O <= rd_data_reg[3'h7 - bit_cnt_reg[2:0]];
        end
    end
    assign SPI_MISO_OE_O = cs_act & cmd_reg[6] & bit_cnt_reg[3];
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            MAIN_IRQ_O  <= `IFS_RESET_BYTE;
            aux_irq_reg <= `IFS_RESET_BYTE;
        end else if (set_def) begin
            // RQ1 default clears main
            MAIN_IRQ_O  <= `IFS_RESET_BYTE;
            // RQ9 default clears aux
            aux_irq_reg <= `IFS_RESET_BYTE;
        end else begin
            // RQ2 read clears upper
            MAIN_IRQ_O[7:1] <= (rd_main ? 7'h00 : MAIN_IRQ_O[7:1]) | main_set;
            // RQ9 read clears aux
            aux_irq_reg <= (rd_aux ? 8'h00 : aux_irq_reg) | aux_set;
            // RQ3 summary follows aux
            MAIN_IRQ_O[0] <= (rd_aux ? 1'b0 : MAIN_IRQ_O[0]) | (|aux_set);
        end
    end
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            fifo_count_reg   <= 6'h00;
            rd_ptr_reg       <= 5'h00;
            wr_ptr_reg       <= 5'h00;
            fifo_status2_reg <= `IFS_RESET_BYTE;
            FIFO_POP_DATA_O  <= 8'h00;
        end else if (set_def | clr_cmd) begin
            // RQ11 clear status
            fifo_count_reg   <= 6'h00;
            rd_ptr_reg       <= 5'h00;
            wr_ptr_reg       <= 5'h00;
            fifo_status2_reg <= `IFS_RESET_BYTE;
        end else begin
            // RQ10 unread count
            fifo_count_reg <= fifo_count_reg + {5'h00, do_push} - {5'h00, do_pop};
            if (do_push) begin
                // RQ5 data kept
                fifo_mem_reg[wr_ptr_reg] <= FIFO_PUSH_DATA_I;
                wr_ptr_reg <= wr_ptr_reg + 5'h01;
            end
            if (do_pop) begin
                FIFO_POP_DATA_O <= fifo_mem_reg[rd_ptr_reg];
                rd_ptr_reg <= rd_ptr_reg + 5'h01;
            end
            // RQ12 underflow overflow
            fifo_status2_reg[`IFS_ST2_UNDERFLOW] <= fifo_status2_reg[`IFS_ST2_UNDERFLOW] | unf_ev;
            fifo_status2_reg[`IFS_ST2_OVERFLOW]  <= fifo_status2_reg[`IFS_ST2_OVERFLOW] | ovr_ev;
            if (EV_RX_END_I) begin
                // RQ13 incomplete last byte
                fifo_status2_reg[`IFS_ST2_INCOMPLETE] <= LAST_INCOMPLETE_I;
                fifo_status2_reg[3:1] <= LAST_INCOMPLETE_I ? LAST_BYTE_BITS_I : 3'h0;
                // RQ14 missing parity
                fifo_status2_reg[`IFS_ST2_NOPARITY] <= MISSING_PARITY_LAST_I;
            end
        end
    end
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            tx_high_reg <= 5'h00;
            tx_low_reg  <= 8'h00;
        end else if (set_def) begin
            // RQ19 count reset
            tx_high_reg    <= 5'h00;
            tx_low_reg[7:3] <= 5'h00;
        end else if (wr_done) begin
            // RQ15 split count
            if (cmd_reg[5:0] == `IFS_OFF_TX_HIGH)
                tx_high_reg <= in_byte[4:0];
            if (cmd_reg[5:0] == `IFS_OFF_TX_LOW)
                tx_low_reg <= in_byte;
        end
    end
    assign TX_FULL_BYTES_O = {tx_high_reg, tx_low_reg[7:3]};
    // RQ17 RQ18 split bits gate
    assign TX_SPLIT_BITS_O = (LEVEL3_MODE_I & BITSTREAM_TX_I) ? tx_low_reg[2:0] : 3'h0;
endmodule // ifs_regs

// file: verification/ifs_regs_props.sv
/*
 Port checker for the interrupt flag, FIFO status and transmit length bank.
 Assumes it is bound to ifs_regs and sees only its ports.
*/
`timescale 1ns/10ps
module ifs_regs_props (
    input wire       SYS_CLK_I,
    input wire       RESET_I,
    input wire       SPI_CS_N_I,
    input wire       SPI_MISO_OE_O,
    input wire       EV_POWER_UP_I,
    input wire       EV_RX_START_I,
    input wire       EV_RX_END_I,
    input wire       EV_CRC_ERR_I,
    input wire       LEVEL3_MODE_I,
    input wire       BITSTREAM_TX_I,
    input wire [9:0] TX_FULL_BYTES_O,
    input wire [2:0] TX_SPLIT_BITS_O,
    input wire [7:0] MAIN_IRQ_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    main_reset_a: assert property ($fell(RESET_I) |-> MAIN_IRQ_O == 8'h00)
        else $error("main flags not clear after reset");
    count_reset_a: assert property ($fell(RESET_I) |-> TX_FULL_BYTES_O == 10'h000)
        else $error("tx count not clear after reset");
    pu_flag_a: assert property (EV_POWER_UP_I |=> MAIN_IRQ_O[7])
        else $error("power-up flag not set");
    rxs_cause_a: assert property ($rose(MAIN_IRQ_O[4]) |-> $past(EV_RX_START_I))
        else $error("rx start flag set without cause");
    rxe_flag_a: assert property (EV_RX_END_I |=> MAIN_IRQ_O[3])
        else $error("rx end flag not set");
    aux_sum_a: assert property (EV_CRC_ERR_I |-> ##[1:2] MAIN_IRQ_O[0])
        else $error("aux summary not set");
    // Sync lag lets the clear land a few cycles after the select rises
    bit0_hold_a: assert property ($fell(MAIN_IRQ_O[0]) |-> !SPI_CS_N_I || !$past(SPI_CS_N_I, 5))
        else $error("aux summary cleared outside a frame");
    split_gate_a: assert property ((!(LEVEL3_MODE_I && BITSTREAM_TX_I))[*2] |-> TX_SPLIT_BITS_O == 3'h0)
        else $error("split bits shown outside bit-stream mode");
    cover property ($rose(SPI_MISO_OE_O));
    cover property ($fell(MAIN_IRQ_O[0]));
    cover property (TX_SPLIT_BITS_O != 3'h0);
endmodule // ifs_regs_props

// file: verification/ifs_host.sv
/*
 Host serial master model: mode 0, MSB first, 16-bit frames.
 Assumes a 40 MHz bench clock; SCLK stands low between frames.
*/
`timescale 1ns/10ps
module ifs_host (
    input  wire clk_i,
    input  wire miso_i,
    input  wire miso_oe_i,
    output reg  sclk_o = 1'b0,
    output reg  cs_n_o = 1'b1,
    output reg  mosi_o = 1'b0
);
    integer i;
    // Four bench clocks a half period give the 200 ns SCLK
    task xfer(input [15:0] w, output [7:0] rd);
        begin
            @(posedge clk_i) cs_n_o <= 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                mosi_o <= w[i];
                repeat (4) @(posedge clk_i);
                if (i < 8)
                    rd[i] = miso_oe_i ? miso_i : 1'bx;
                sclk_o <= 1'b1;
                repeat (4) @(posedge clk_i);
                sclk_o <= 1'b0;
            end
            repeat (4) @(posedge clk_i);
            cs_n_o <= 1'b1;
            // Released line flips so a stale bit cannot pass for data
            mosi_o <= ~mosi_o;
            repeat (6) @(posedge clk_i);
        end
    endtask
endmodule // ifs_host

// file: verification/tb.sv
/*
 Self-checking bench for the flag, FIFO status and length bank.
 Assumes ifs_regs, its checker and the host model are compiled alongside.
*/
`timescale 1ns/10ps
`include "ifs_map.vh"
module tb;
    reg         clk = 1'b0, rst = 1'b1, push = 1'b0, pop = 1'b0, h_ee = 1'b0;
    reg         rx_act = 1'b0, inc = 1'b0, miss = 1'b0, l3 = 1'b0, bs = 1'b0;
    reg  [12:0] ev = 13'h0;
    reg  [7:0]  pdata = 8'h00;
    reg  [2:0]  lbits = 3'h0;
    reg  [7:0]  r;
    wire        sclk, cs_n, mosi, miso, oe;
    wire [7:0]  popd, main;
    wire [9:0]  txf;
    wire [2:0]  txs;
    integer     bad_count = 0, n_checks = 0, cyc = 0, k;
    ifs_regs i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
        .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(oe), .EV_POWER_UP_I(ev[12]),
        .EV_WAKE_ACTIVE_I(ev[11]), .EV_WAKE_CMD_I(ev[10]), .EV_RX_START_I(ev[9]),
        .EV_RX_END_I(ev[8]), .EV_TX_END_I(ev[7]), .EV_DESELECT_I(ev[6]),
        .EV_FRAMING_ERR_I(ev[5]), .EV_PARITY_ERR_I(ev[4]), .EV_CRC_ERR_I(ev[3]),
        .EV_EE_DONE_I(ev[2]), .EV_EE_ERR_I(ev[1]), .EV_EE_CUT_I(ev[0]),
        .EE_FROM_HOST_I(h_ee), .RX_ACTIVE_I(rx_act), .FIFO_PUSH_I(push),
        .FIFO_PUSH_DATA_I(pdata), .LAST_INCOMPLETE_I(inc), .LAST_BYTE_BITS_I(lbits),
        .MISSING_PARITY_LAST_I(miss), .LEVEL3_MODE_I(l3), .BITSTREAM_TX_I(bs),
        .FIFO_POP_I(pop), .FIFO_POP_DATA_O(popd), .TX_FULL_BYTES_O(txf),
        .TX_SPLIT_BITS_O(txs), .MAIN_IRQ_O(main));
    ifs_host i_host (.clk_i(clk), .miso_i(miso), .miso_oe_i(oe), .sclk_o(sclk),
        .cs_n_o(cs_n), .mosi_o(mosi));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        begin
            if (bad_count == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [9:0] seen, input [9:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rd(input [5:0] a, input [9:0] exp, input string nm);
        begin
            i_host.xfer({2'b01, a, 8'h00}, r);
            chk(nm, {2'h0, r}, exp);
        end
    endtask
    task wr(input [7:0] b0, input [7:0] d);
        i_host.xfer({b0, d}, r);
    endtask
    task pulse(input [12:0] v);
        begin
            @(posedge clk) ev <= v;
            @(posedge clk) ev <= 13'h0;
            repeat (4) @(posedge clk);
        end
    endtask
    task t_reset;
        begin
            rd(`IFS_OFF_MAIN_IRQ, 10'h0, "main");
            rd(`IFS_OFF_AUX_IRQ, 10'h0, "aux");
            rd(`IFS_OFF_FIFO_STAT1, 10'h0, "stat1");
            rd(`IFS_OFF_FIFO_STAT2, 10'h0, "stat2");
            rd(`IFS_OFF_TX_HIGH, 10'h0, "tx high");
        end
    endtask
    task t_main;
        begin
            pulse(13'h1e88);
            rd(`IFS_OFF_MAIN_IRQ, 10'hf5, "main");
            rd(`IFS_OFF_MAIN_IRQ, 10'h01, "main kept");
            rd(`IFS_OFF_AUX_IRQ, 10'h10, "aux crc");
            rd(`IFS_OFF_MAIN_IRQ, 10'h00, "main cleared");
            rd(`IFS_OFF_AUX_IRQ, 10'h00, "aux cleared");
        end
    endtask
    task t_aux;
        begin
            h_ee <= 1'b1;
            for (k = 0; k < 7; k = k + 1) begin
                pulse(13'h1 << k);
                rd(`IFS_OFF_AUX_IRQ, k > 2 ? 10'h10 << (k - 3) : 10'h1 << k, "aux");
            end
            h_ee <= 1'b0;
            pulse(13'h4);
            rd(`IFS_OFF_AUX_IRQ, 10'h0, "aux not host");
        end
    endtask
    task t_fifo;
        begin
            pulse(13'h10);
            for (k = 0; k < 33; k = k + 1) begin
                @(posedge clk) push <= 1'b1;
                pdata <= k[7:0];
                @(posedge clk) push <= 1'b0;
            end
            rd(`IFS_OFF_FIFO_STAT1, 10'h20, "stat1 full");
            rd(`IFS_OFF_FIFO_STAT2, 10'h20, "stat2 over");
            rd(`IFS_OFF_AUX_IRQ, 10'h28, "aux over");
            for (k = 0; k < 33; k = k + 1) begin
                @(posedge clk) pop <= 1'b1;
                @(posedge clk) pop <= 1'b0;
                #1;
                if (k < 32)
                    chk("pop data", {2'h0, popd}, k[9:0]);
            end
            // Transmit side drained past the low mark, underflow raised the summary
            rd(`IFS_OFF_MAIN_IRQ, 10'h03, "main water");
            @(posedge clk) inc <= 1'b1;
            lbits <= 3'h5;
            miss <= 1'b1;
            pulse(13'h100);
            rd(`IFS_OFF_FIFO_STAT2, 10'h7b, "stat2 last");
            rd(`IFS_OFF_AUX_IRQ, 10'h48, "aux under");
            wr({2'b10, `IFS_CMD_CLEAR}, 8'h00);
            rd(`IFS_OFF_FIFO_STAT1, 10'h0, "stat1 clr");
            rd(`IFS_OFF_FIFO_STAT2, 10'h0, "stat2 clr");
        end
    endtask
    task t_tx;
        begin
            // Count 2b5h stays within 10 bits, split across both offsets
            wr({2'b00, `IFS_OFF_TX_HIGH}, 8'h15);
            wr({2'b00, `IFS_OFF_TX_LOW}, 8'had);
            chk("tx count", txf, 10'h2b5);
            chk("split off", {7'h0, txs}, 10'h0);
            @(posedge clk) l3 <= 1'b1;
            bs <= 1'b1;
            repeat (3) @(posedge clk);
            chk("split on", {7'h0, txs}, 10'h5);
            rd(`IFS_OFF_TX_LOW, 10'had, "tx low");
            wr({2'b00, `IFS_OFF_FIFO_STAT1}, 8'hff);
            rd(`IFS_OFF_FIFO_STAT1, 10'h0, "stat1 ro");
            rd(6'h3f, 10'h0, "unmapped");
            wr({2'b10, `IFS_CMD_SET_DEFAULT}, 8'h00);
            chk("tx default", txf, 10'h0);
            rd(`IFS_OFF_MAIN_IRQ, 10'h0, "main default");
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset;
        t_main;
        t_aux;
        t_fifo;
        t_tx;
        tally_and_finish;
    end
endmodule // tb
bind ifs_regs ifs_regs_props i_props (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
    .SPI_CS_N_I(SPI_CS_N_I), .SPI_MISO_OE_O(SPI_MISO_OE_O), .EV_POWER_UP_I(EV_POWER_UP_I),
    .EV_RX_START_I(EV_RX_START_I), .EV_RX_END_I(EV_RX_END_I), .EV_CRC_ERR_I(EV_CRC_ERR_I),
    .LEVEL3_MODE_I(LEVEL3_MODE_I), .BITSTREAM_TX_I(BITSTREAM_TX_I),
    .TX_FULL_BYTES_O(TX_FULL_BYTES_O), .TX_SPLIT_BITS_O(TX_SPLIT_BITS_O),
    .MAIN_IRQ_O(MAIN_IRQ_O));
